// file: verilog/arsq_pkg.sv
// Package for the auto-reclose sequencer: register map, timing constants, state codes.
// Assumes a 20 MHz system clock and a classic Wishbone register bus.
`default_nettype none
package arsq_pkg;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned TICK_US = 10000;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1000000 * TICK_US;
    localparam logic [15:0] DEAD_DEF = 16'h01f4;
    localparam logic [15:0] RECL_DEF = 16'h03e8;
    localparam logic [15:0] STD_DEF = 16'h0002;
    localparam logic [15:0] TIME_MIN = 16'h0002;
    localparam logic [15:0] TIME_MAX = 16'h7530;
    localparam int unsigned NSHOT = 5;

    // ------------------------------------------------------------------
    // Register map (byte offsets)
    // ------------------------------------------------------------------
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STATUS = 8'h04;
    localparam logic [7:0] A_IRQ_ST = 8'h08;
    localparam logic [7:0] A_IRQ_MSK = 8'h0c;
    localparam logic [7:0] A_RECL = 8'h10;
    localparam logic [7:0] A_TOTAL = 8'h14;
    localparam logic [7:0] A_FAIL = 8'h18;
    localparam logic [7:0] A_TIMER = 8'h1c;
    localparam logic [7:0] A_DEAD0 = 8'h20;
    localparam logic [7:0] A_START0 = 8'h40;
    localparam logic [7:0] A_DISC0 = 8'h60;
    localparam logic [7:0] A_SCNT0 = 8'h80;
    localparam logic [4:0] CTRL_RST = 5'h01;
    localparam int unsigned NIRQ = 4;

    typedef enum logic [3:0] {
        ST_INIT, ST_RECLAIM, ST_READY, ST_WAIT_OPEN, ST_WAIT_CLOSE,
        ST_DISCR, ST_LOCKED, ST_FINAL_TRIP, ST_CB_FAIL, ST_INHIBIT
    } arsq_state_type;

    typedef enum logic [1:0] {
        TM_RECLAIM, TM_START, TM_DEAD, TM_DISCR
    } arsq_timer_type;

    // Clamps a written time setting into its legal range.
    function automatic logic [15:0] arsq_clamp(input logic [15:0] v);
        if (v < TIME_MIN) begin
            return TIME_MIN;
        end
        if (v > TIME_MAX) begin
            return TIME_MAX;
        end
        return v;
    endfunction
endpackage
`default_nettype wire

// file: verilog/arsq_tick.sv
// Divider that produces the 10 ms timebase enable.
// Assumes one free-running system clock.
`timescale 1ns/1ns
`default_nettype none
module arsq_tick #(
    parameter int unsigned DIV = arsq_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Tick
    output logic tick_o
);
    import arsq_pkg::*;
    logic [23:0] cnt_r, cnt_nxt;

    // Counts down and pulses once per period.
    always_comb begin
        cnt_nxt = (cnt_r == 24'h000000) ? 24'(DIV - 1) : cnt_r - 24'h000001;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= 24'(DIV - 1);
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
    assign tick_o = (cnt_r == 24'h000000);
endmodule // arsq_tick
`default_nettype wire

// file: verilog/arsq_sync.sv
// Two-flop synchroniser for a bundle of pin inputs.
// Assumes inputs asynchronous to clk_i.
`timescale 1ns/1ns
`default_nettype none
module arsq_sync #(
    parameter int unsigned W = 5
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] s1_r, s2_r;

    // First stage feeds only the second stage.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_r <= '0;
            s2_r <= '0;
        end else begin
            s1_r <= d_i;
            s2_r <= s1_r;
        end
    end
    assign q_o = s2_r;
endmodule // arsq_sync
`default_nettype wire

// file: verilog/arsq_top.sv
// Auto-reclose sequencer with Wishbone register file and interrupt.
// Assumes breaker feedback, request lines and block input are async pins.
//
// Chosen here: the register offsets and the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
module arsq_top #(
    parameter int unsigned TICK_DIV = arsq_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Protection inputs
    input wire logic [1:0] req_i,
    input wire logic block_i,
    input wire logic cb_open_i,
    input wire logic cb_closed_i,
    // Breaker commands
    output logic trip_command_output_o,
    output logic reclose_command_output_o,
    // Status
    output arsq_pkg::arsq_state_type state_o,
    output logic [2:0] shot_o,
    output logic irq_o
);
    import arsq_pkg::*;

    // ------------------------------------------------------------------
    // Input synchronisation and timebase
    // ------------------------------------------------------------------
    logic [4:0] pins_s;
    logic tick;
    logic [1:0] req_s;
    logic oc, blk, cbo, cbc;
    arsq_sync #(.W(5)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({req_i, block_i, cb_open_i, cb_closed_i}),
        .q_o(pins_s)
    );
    arsq_tick #(.DIV(TICK_DIV)) u_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_o(tick)
    );
    // Bundle order is request lines, block, breaker open, breaker closed.
    assign req_s = pins_s[4:3];
    assign blk = pins_s[2];
    assign cbo = pins_s[1];
    assign cbc = pins_s[0];
    assign oc = |req_s;

    // ------------------------------------------------------------------
    // Settings and counters
    // ------------------------------------------------------------------
    // Time settings are held in timebase ticks; line 1 shares the line 0 layout.
    logic [15:0] dead_r [NSHOT];
    logic [15:0] start_r [2][NSHOT];
    logic [15:0] disc_r [2][NSHOT];
    logic [15:0] scnt_r [2][NSHOT];
    logic [15:0] recl_r, total_r, fail_r;
    logic [NIRQ-1:0] ist_r, imsk_r;
    logic ctl_en_r;

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    arsq_state_type st_r, st_nxt;
    arsq_timer_type tm_r, tm_nxt;
    logic [2:0] shot_r, shot_nxt;
    logic line_r, line_nxt;
    logic [15:0] tmr_r, tmr_nxt;
    logic trip_r, trip_nxt, clo_r, clo_nxt;
    logic ev_start, ev_fail, ev_ok, ev_final;
    // A sequence start, as opposed to the start of any later shot.
    logic ev_seq;
    logic expired;

    assign expired = (tmr_r == 16'h0000);

    // Next-state logic for the shot sequence.
    always_comb begin
        st_nxt = st_r;
        tm_nxt = tm_r;
        shot_nxt = shot_r;
        line_nxt = line_r;
        tmr_nxt = (tick && !expired) ? tmr_r - 16'h0001 : tmr_r;
        trip_nxt = trip_r;
        clo_nxt = clo_r;
        ev_start = 1'b0;
        ev_fail = 1'b0;
        ev_ok = 1'b0;
        ev_final = 1'b0;
        ev_seq = 1'b0;
        unique case (st_r)
            // Leaves init at once, ready or inhibited as the enable says.
            ST_INIT: begin
                st_nxt = ctl_en_r ? ST_READY : ST_INHIBIT;
                shot_nxt = 3'd1;
            end
            // Sequencer disabled; overcurrent is ignored here.
            ST_INHIBIT: begin
                if (ctl_en_r) begin
                    st_nxt = ST_READY;
                end
            end
            // Waits for a request at shot 1.
            ST_READY: begin
                if (!ctl_en_r) begin
                    st_nxt = ST_INHIBIT;
                end else if (oc) begin
                    line_nxt = !req_s[0];
                    shot_nxt = 3'd1;
                    tm_nxt = TM_START;
                    tmr_nxt = start_r[!req_s[0]][0];
                    st_nxt = ST_LOCKED;
                    ev_start = 1'b1;
                    ev_seq = 1'b1;
                end
            end
            ST_LOCKED: begin
                // Start delay running; current must persist.
                if (!oc) begin
                    st_nxt = ST_READY;
                end else if (expired) begin
                    trip_nxt = 1'b1;
                    st_nxt = ST_WAIT_OPEN;
                end
            end
            // Trip stands until the breaker reports open.
            ST_WAIT_OPEN: begin
                if (cbo) begin
                    trip_nxt = 1'b0;
                    tm_nxt = TM_DEAD;
                    tmr_nxt = dead_r[shot_r - 3'd1];
                    st_nxt = ST_WAIT_CLOSE;
                end
            end
            // Dead time runs; reclose stands until the breaker reports closed.
            ST_WAIT_CLOSE: begin
                if (clo_r && cbc) begin
                    clo_nxt = 1'b0;
                    tm_nxt = TM_DISCR;
                    tmr_nxt = disc_r[line_r][shot_r - 3'd1];
                    st_nxt = ST_DISCR;
                end else if (expired && !blk) begin
                    clo_nxt = 1'b1;
                end
            end
            // A fault still present at expiry fails this shot.
            ST_DISCR: begin
                if (!oc) begin
                    tm_nxt = TM_RECLAIM;
                    tmr_nxt = recl_r;
                    st_nxt = ST_RECLAIM;
                end else if (expired) begin
                    trip_nxt = 1'b1;
                    ev_fail = 1'b1;
                    if (shot_r == 3'(NSHOT)) begin
                        ev_final = 1'b1;
                        st_nxt = ST_FINAL_TRIP;
                    end else begin
                        shot_nxt = shot_r + 3'd1;
                        ev_start = 1'b1;
                        st_nxt = ST_WAIT_OPEN;
                    end
                end
            end
            // A returning fault goes back to discrimination of the same shot.
            ST_RECLAIM: begin
                if (oc) begin
                    tm_nxt = TM_DISCR;
                    tmr_nxt = disc_r[line_r][shot_r - 3'd1];
                    st_nxt = ST_DISCR;
                end else if (expired) begin
                    ev_ok = 1'b1;
                    shot_nxt = 3'd1;
                    st_nxt = ST_READY;
                end
            end
            // All shots used; waits for an open breaker and no fault.
            ST_FINAL_TRIP: begin
                if (cbo) begin
                    trip_nxt = 1'b0;
                    if (!oc) begin
                        shot_nxt = 3'd1;
                        st_nxt = ST_READY;
                    end
                end
            end
            // Not entered by this logic; recovers through init.
            ST_CB_FAIL: begin
                st_nxt = ST_INIT;
            end
        endcase
    end

    // Registers the sequencer; reset parks it in init at shot 1.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= ST_INIT;
            tm_r <= TM_RECLAIM;
            shot_r <= 3'd1;
            line_r <= 1'b0;
            tmr_r <= 16'h0000;
            trip_r <= 1'b0;
            clo_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            tm_r <= tm_nxt;
            shot_r <= shot_nxt;
            line_r <= line_nxt;
            tmr_r <= tmr_nxt;
            trip_r <= trip_nxt;
            clo_r <= clo_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Breaker commands and status
    // ------------------------------------------------------------------
    assign trip_command_output_o = trip_r;
    assign reclose_command_output_o = clo_r;
    assign state_o = st_r;
    assign shot_o = shot_r;

    // ------------------------------------------------------------------
    // Wishbone register file
    // ------------------------------------------------------------------
    logic wr;
    logic [31:0] rdat, dat_r, dat_nxt;
    logic ack_r, ack_nxt;
    logic [2:0] gi;
    logic gl;
    logic [NIRQ-1:0] iev;

    // Writes need all byte lanes and land in the cycle the request is taken.
    // Line 1 slots fold onto shots by the slot index modulo five.
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r && (&wb_sel_i);
    assign gi = 3'(wb_adr_i[4:2] % 3'd5);
    assign gl = wb_adr_i[4:2] >= 3'd5;
    assign iev = {ev_final, ev_ok, ev_fail, ev_start};

    // Read mux; unmapped offsets read zero.
    always_comb begin
        rdat = 32'h00000000;
        unique case (wb_adr_i[7:5])
            3'h0: begin
                unique case (wb_adr_i[4:2])
                    3'h0: rdat = {31'h0, ctl_en_r};
                    3'h1: rdat = {24'h0, 2'(tm_r), 3'(shot_r), 3'h0} | {28'h0, 4'(st_r)} << 8;
                    3'h2: rdat = {28'h0, ist_r};
                    3'h3: rdat = {28'h0, imsk_r};
                    3'h4: rdat = {16'h0, recl_r};
                    3'h5: rdat = {16'h0, total_r};
                    3'h6: rdat = {16'h0, fail_r};
                    default: rdat = {14'h0, 2'(tm_r), tmr_r};
                endcase
            end
            3'h1: rdat = (wb_adr_i[4:2] < 3'd5) ? {16'h0, dead_r[wb_adr_i[4:2]]} : 32'h0;
            3'h2: rdat = {16'h0, start_r[gl][gi]};
            3'h3: rdat = {16'h0, disc_r[gl][gi]};
            3'h4: rdat = {16'h0, scnt_r[gl][gi]};
            default: rdat = 32'h00000000;
        endcase
        ack_nxt = wb_cyc_i && wb_stb_i && !ack_r;
        dat_nxt = ack_nxt ? rdat : dat_r;
    end

    // Registers, counters and sticky interrupt bits; hardware set wins.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0;
            ctl_en_r <= 1'b1;
            recl_r <= RECL_DEF;
            total_r <= 16'h0;
            fail_r <= 16'h0;
            ist_r <= '0;
            imsk_r <= '0;
            for (int s = 0; s < NSHOT; s++) begin
                dead_r[s] <= DEAD_DEF;
                for (int l = 0; l < 2; l++) begin
                    start_r[l][s] <= STD_DEF;
                    disc_r[l][s] <= STD_DEF;
                    scnt_r[l][s] <= 16'h0;
                end
            end
        end else begin
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
            // Shot starts count per line and shot; only sequence starts count in total.
            if (ev_start) begin
                scnt_r[line_nxt][shot_nxt - 3'd1] <= scnt_r[line_nxt][shot_nxt - 3'd1] + 16'h1;
            end
            if (ev_seq) begin
                total_r <= total_r + 16'h1;
            end
            if (ev_fail) begin
                fail_r <= fail_r + 16'h1;
            end
            ist_r <= (wr && wb_adr_i == A_IRQ_ST) ? ((ist_r & ~wb_dat_i[NIRQ-1:0]) | iev)
                                                 : (ist_r | iev);
            if (wr) begin
                unique case (wb_adr_i[7:5])
                    3'h0: begin
                        if (wb_adr_i == A_CTRL) begin
                            ctl_en_r <= wb_dat_i[0];
                        end
                        if (wb_adr_i == A_IRQ_MSK) begin
                            imsk_r <= wb_dat_i[NIRQ-1:0];
                        end
                        if (wb_adr_i == A_RECL) begin
                            recl_r <= arsq_clamp(wb_dat_i[15:0]);
                        end
                    end
                    3'h1: begin
                        if (wb_adr_i[4:2] < 3'd5) begin
                            dead_r[wb_adr_i[4:2]] <= arsq_clamp(wb_dat_i[15:0]);
                        end
                    end
                    3'h2: start_r[gl][gi] <= arsq_clamp(wb_dat_i[15:0]);
                    3'h3: disc_r[gl][gi] <= arsq_clamp(wb_dat_i[15:0]);
                    default: begin
                    end
                endcase
            end
        end
    end

    // Bus answer and read data come straight from flip-flops.
    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign irq_o = |(ist_r & imsk_r);
endmodule // arsq_top
`default_nettype wire

// file: testbench/arsq_props.sv
// Checker for the auto-reclose sequencer top level.
// Assumes it is bound to arsq_top and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module arsq_props #(
    parameter int unsigned TICK_DIV = arsq_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Protection side
    input wire logic [1:0] req_i,
    input wire logic block_i,
    input wire logic cb_open_i,
    input wire logic cb_closed_i,
    input wire logic trip_command_output_o,
    input wire logic reclose_command_output_o,
    input wire arsq_pkg::arsq_state_type state_o,
    input wire logic [2:0] shot_o,
    input wire logic irq_o
);
    import arsq_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ------------------------------------------------------------------
    // Bus handshake and sequencer outputs
    // ------------------------------------------------------------------
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_init_to_ready: assert property ($fell(rst_i) |-> state_o == ST_INIT ##1 state_o == ST_READY)
        else $error("no init to ready after reset");
    a_shot_range: assert property (shot_o >= 3'h1 && shot_o <= 3'h5)
        else $error("shot number out of range");
    a_shot_step: assert property ($changed(shot_o) |-> shot_o == $past(shot_o) + 3'h1 || shot_o == 3'h1)
        else $error("shot number jumped");
    a_cmds_exclusive: assert property (!(trip_command_output_o && reclose_command_output_o))
        else $error("trip and reclose together");
    a_trip_release: assert property (cb_open_i [*6] |-> !trip_command_output_o)
        else $error("trip held after breaker open");
    a_close_release: assert property (cb_closed_i [*6] |-> !reclose_command_output_o)
        else $error("reclose held after breaker closed");
    a_block_holds: assert property (block_i [*4] |=> !$rose(reclose_command_output_o))
        else $error("reclose issued while blocked");
    a_reclose_state: assert property (reclose_command_output_o |-> state_o == ST_WAIT_CLOSE)
        else $error("reclose outside wait close state");
endmodule // arsq_props
`default_nettype wire

// file: testbench/arsq_breaker.sv
// Behavioural circuit breaker with open and closed position contacts.
// Assumes command levels from the sequencer on the same clock.
`timescale 1ns/1ns
`default_nettype none
module arsq_breaker #(
    parameter int DLY = 3
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Commands
    input wire logic trip_i,
    input wire logic close_i,
    // Position
    output logic open_o,
    output logic closed_o
);
    int cnt;
    // Mechanism moves DLY+1 cycles after a command appears; starts closed.
    always @(posedge clk_i) begin
        if (rst_i) begin
            open_o <= 1'b0;
            cnt <= 0;
        end else if ((trip_i && !open_o) || (close_i && open_o)) begin
            cnt <= cnt + 1;
            if (cnt == DLY) begin
                open_o <= trip_i;
                cnt <= 0;
            end
        end else begin
            cnt <= 0;
        end
    end
    assign closed_o = !open_o;
endmodule // arsq_breaker
`default_nettype wire

// file: testbench/testbench.sv
// Self-checking bench for the auto-reclose sequencer.
// Assumes a short tick divider and the breaker model on the pins.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import arsq_pkg::*;
    localparam int TD = 4;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, block = 0, ack, trip, recl, irq;
    logic [7:0] adr = '0;
    logic [3:0] sel = '0;
    logic [31:0] wdat = '0, rdat, dat_o;
    logic [1:0] req = '0;
    logic cb_open, cb_closed;
    logic [2:0] shot;
    arsq_state_type state;
    int mismatches = 0, tests_run = 0, n, d1, d2;
    logic [7:0] r_adr[9] = '{A_CTRL, A_RECL, A_DEAD0, 8'h30, A_START0, A_DISC0, A_TOTAL, A_FAIL, 8'hfc};
    logic [31:0] r_exp[9] = '{1, 32'h3e8, 32'h1f4, 32'h1f4, 2, 2, 0, 0, 0};

    always #25 clk_i = ~clk_i;

    arsq_top #(.TICK_DIV(TD)) i_arsq_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .req_i(req), .block_i(block), .cb_open_i(cb_open),
        .cb_closed_i(cb_closed), .trip_command_output_o(trip), .reclose_command_output_o(recl),
        .state_o(state), .shot_o(shot), .irq_o(irq));
    arsq_breaker i_arsq_breaker (.clk_i(clk_i), .rst_i(rst_i), .trip_i(trip), .close_i(recl),
        .open_o(cb_open), .closed_o(cb_closed));

    // Compares one value and counts the result.
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    // One classic Wishbone cycle; read data is taken at the ack edge.
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1; stb <= 1; we <= w; adr <= a; sel <= 4'hf; wdat <= d;
        @(posedge clk_i);
        for (n = 0; ack !== 1'b1; n++) @(posedge clk_i);
        chk(n, 1, "bus ack latency");
        rdat = dat_o;
        cyc <= 0; stb <= 0; we <= 0;
    endtask

    task rd_chk(input logic [7:0] a, input logic [31:0] e, input string msg);
        wb(0, a, 0);
        chk(rdat, e, msg);
    endtask

    function automatic logic [3:0] cur(input int k);
        return (k == 0) ? {3'h0, trip} : (k == 1) ? {3'h0, recl} : state;
    endfunction

    // Waits for a command or state level under a bound; returns cycles taken.
    task wt(input int k, input logic [3:0] v, input int lim, output int c);
        for (c = 0; c < lim && cur(k) !== v; c++) @(posedge clk_i);
        chk({28'h0, cur(k)}, {28'h0, v}, "awaited level");
    endtask

    task end_sim;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        #(50 * 40000);
        mismatches++;
        end_sim();
    end

    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 0;
        repeat (2) @(posedge clk_i);
        chk(state, ST_READY, "ready after reset");
        chk(shot, 1, "shot after reset");
        // Reset values of the settings and counters, plus an unmapped slot.
        for (int i = 0; i < 9; i++) rd_chk(r_adr[i], r_exp[i], "reset value");
        $display("register defaults done");
        wb(1, 8'hfc, 32'h55); rd_chk(8'hfc, 0, "unmapped write");
        wb(1, 8'h24, 1); rd_chk(8'h24, 2, "dead time low clamp");
        wb(1, 8'h24, 32'hffff); rd_chk(8'h24, 32'h7530, "dead time high clamp");
        wb(1, A_IRQ_MSK, 32'hf); wb(1, A_RECL, 3); wb(1, A_DEAD0, 2); wb(1, 8'h24, 6);
        // Two shots: overcurrent persists through shot 1, clears in shot 2.
        req <= 2'b01;
        wt(0, 1, 400, n);
        chk(state, ST_WAIT_OPEN, "waiting open");
        chk(shot, 1, "first shot");
        wt(0, 0, 100, n);
        wt(1, 1, 400, d1);
        wt(1, 0, 100, n);
        wt(0, 1, 400, n);
        chk(shot, 2, "second shot");
        wt(0, 0, 100, n);
        wt(1, 1, 400, d2);
        chk({31'h0, (d2 - d1 >= 3 * TD) && (d2 - d1 <= 5 * TD)}, 1, "shot dead time");
        req <= 2'b00;
        wt(2, ST_READY, 400, n);
        chk(shot, 1, "back to shot 1");
        rd_chk(A_TOTAL, 1, "total starts");
        rd_chk(A_FAIL, 1, "failed shots");
        rd_chk(A_SCNT0, 1, "shot 1 starts");
        rd_chk(8'h84, 1, "shot 2 starts");
        wb(0, A_IRQ_ST, 0); chk(rdat & 32'hf, 32'h7, "event bits");
        chk({31'h0, irq}, 1, "irq raised");
        wb(1, A_IRQ_MSK, 0); chk({31'h0, irq}, 0, "irq masked");
        wb(1, A_IRQ_MSK, 32'hf); wb(1, A_IRQ_ST, 32'hf);
        rd_chk(A_IRQ_ST, 0, "events cleared"); chk({31'h0, irq}, 0, "irq cleared");
        $display("two shot sequence done");
        // Blocked reclose, then persisting fault up to final trip.
        req <= 2'b01; block <= 1;
        wt(0, 1, 400, n);
        wt(0, 0, 100, n);
        repeat (100) @(posedge clk_i);
        chk({31'h0, recl}, 0, "reclose withheld");
        block <= 0;
        wt(1, 1, 8, n);
        // Shots 3 to 5 keep the default dead time, which dominates this wait.
        wt(2, ST_FINAL_TRIP, 8000, n);
        rd_chk(A_FAIL, 6, "failed shots after lockout");
        rd_chk(A_TOTAL, 2, "total starts again");
        req <= 2'b00;
        wt(2, ST_READY, 400, n);
        $display("final trip sequence done");
        // Disabled sequencer ignores overcurrent.
        wb(1, A_CTRL, 0);
        wt(2, ST_INHIBIT, 10, n);
        req <= 2'b10;
        repeat (40) @(posedge clk_i);
        chk({31'h0, trip}, 0, "no trip when inhibited");
        req <= 2'b00;
        wb(1, A_CTRL, 1);
        wt(2, ST_READY, 20, n);
        $display("inhibit done");
        end_sim();
    end
endmodule // testbench

bind arsq_top arsq_props #(.TICK_DIV(TICK_DIV)) i_arsq_props (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .req_i(req_i), .block_i(block_i), .cb_open_i(cb_open_i), .cb_closed_i(cb_closed_i),
    .trip_command_output_o(trip_command_output_o),
    .reclose_command_output_o(reclose_command_output_o), .state_o(state_o), .shot_o(shot_o),
    .irq_o(irq_o));
`default_nettype wire
